// File: rtl/crt_pkg.sv
/*
 * Shared constants and types for the card reader command and interrupt
 * block: register indices, reset values, command codes and field bits.
 * Assumes byte-wide registers and a single 250 MHz system clock.
 */
package crt_pkg;

  // Register file layout
  localparam int REG_COUNT = 25;
  localparam logic [4:0] IDX_P1_CFG0  = 5'h00;
  localparam logic [4:0] IDX_P1_CFG1  = 5'h01;
  localparam logic [4:0] IDX_P1_PIN   = 5'h05;
  localparam logic [4:0] IDX_TMR_HI   = 5'h06;
  localparam logic [4:0] IDX_COMMON   = 5'h08;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h0a;
  localparam logic [4:0] IDX_P2_CFG0  = 5'h0b;
  localparam logic [4:0] IDX_P3_CFG0  = 5'h0e;
  localparam logic [4:0] IDX_P4_CFG0  = 5'h10;
  localparam logic [4:0] IDX_P5_CFG0  = 5'h12;
  localparam logic [4:0] IDX_AUX      = 5'h14;
  localparam logic [4:0] IDX_REGUL    = 5'h15;
  localparam logic [4:0] IDX_SLEW1    = 5'h16;
  localparam logic [4:0] IDX_SLEW2    = 5'h17;
  localparam logic [4:0] CFG0_IDX [5] = '{IDX_P1_CFG0, IDX_P2_CFG0,
                                          IDX_P3_CFG0, IDX_P4_CFG0,
                                          IDX_P5_CFG0};

  // Values after reset (transition timer holds 400)
  localparam logic [7:0] PIN_RESET    = 8'h60;
  localparam logic [7:0] TMR_HI_RESET = 8'h01;
  localparam logic [7:0] TMR_LO_RESET = 8'h90;

  // Command codes
  localparam logic [7:0] CMD_RESET  = 8'hff;
  localparam logic [7:0] CMD_TIMER  = 8'hfc;
  localparam logic [7:0] CMD_COMMON = 8'hf8;
  localparam logic [7:0] CMD_P2     = 8'hf9;
  localparam logic [7:0] CMD_P3     = 8'hfa;
  localparam logic [7:0] CMD_P4     = 8'hfb;
  localparam logic [7:0] CMD_P5     = 8'hfd;
  localparam logic [7:0] CMD_AUX    = 8'hfe;
  localparam logic [7:0] CMD_SLEW   = 8'hf7;
  localparam logic [7:0] GC_RESET   = 8'h06;
  localparam logic [7:0] GC_ADDR    = 8'h00;
  localparam logic [3:0] ADDR_HIGH  = 4'h4;

  // Field bit positions
  localparam int B_TMO      = 5;
  localparam int B_CHG      = 4;
  localparam int B_OC       = 3;
  localparam int B_FLT      = 2;
  localparam int B_SETTLED  = 7;
  localparam int B_GOOD     = 6;
  localparam int B_PRIM_OFF = 5;
  localparam int B_SEC_OFF  = 5;
  localparam logic [1:0] SLEW_AUTO = 2'h0;

  // Read groups, one per write command family
  typedef enum logic [2:0] {
    G_SC1 = 3'h0, G_COM = 3'h1, G_P2 = 3'h2, G_P3 = 3'h3,
    G_P4 = 3'h4, G_P5 = 3'h5, G_AUX = 3'h6, G_SLEW = 3'h7
  } crt_grp_t;

  typedef struct packed {
    logic       ok;
    logic       rst;
    crt_grp_t   grp;
    logic [4:0] base;
    logic [2:0] len;
  } crt_cmd_t;

  // Serial slave states, Gray along idle-addr-write-read-hold
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_WRITE = 3'b011,
    S_READ = 3'b010, S_HOLD = 3'b110
  } crt_twi_st_t;

  function automatic crt_cmd_t crt_decode(input logic [7:0] c);
    crt_cmd_t r;
    r = '{ok: 1'b1, rst: 1'b0, grp: G_SC1, base: 5'h00, len: 3'h0};
    if (c[7:6] == 2'b10) begin
      r.base = IDX_P1_CFG1;
      r.len  = 3'h4;
    end else if (c[7]) begin
      unique case (c)
        CMD_RESET:  r.rst = 1'b1;
        CMD_TIMER:  r = '{1'b1, 1'b0, G_SC1, IDX_TMR_HI, 3'h2};
        CMD_COMMON: r = '{1'b1, 1'b0, G_COM, IDX_COMMON, 3'h3};
        CMD_P2:     r = '{1'b1, 1'b0, G_P2, IDX_P2_CFG0, 3'h3};
        CMD_P3:     r = '{1'b1, 1'b0, G_P3, IDX_P3_CFG0, 3'h2};
        CMD_P4:     r = '{1'b1, 1'b0, G_P4, IDX_P4_CFG0, 3'h2};
        CMD_P5:     r = '{1'b1, 1'b0, G_P5, IDX_P5_CFG0, 3'h2};
        CMD_AUX:    r = '{1'b1, 1'b0, G_AUX, IDX_AUX, 3'h2};
        CMD_SLEW:   r = '{1'b1, 1'b0, G_SLEW, IDX_SLEW1, 3'h3};
        default:    r.ok = 1'b0;
      endcase
    end
    return r;
  endfunction

endpackage

// File: rtl/crt_twi_if.sv
/*
 * Byte-level carrier between the serial slave and the command core.
 * Both ends run on the same system clock.
 */
interface crt_twi_if;
  logic       byteStb;
  logic [7:0] byteData;
  logic       isCmd;
  logic       genCall;
  logic       rdStart;
  logic       rdAck;
  logic [7:0] rdData;
  logic [1:0] devAddr;

  modport slave (output byteStb, byteData, isCmd, genCall, rdStart,
                 rdAck, input rdData, devAddr);
  modport core  (input byteStb, byteData, isCmd, genCall, rdStart,
                 rdAck, output rdData, devAddr);
endinterface

// File: rtl/crt_twi_slave.sv
/*
 * Two-wire serial slave: oversamples the link clock and data, acks its
 * own address and the general call, delivers written bytes and serves
 * read bytes. Assumes the link runs far slower than the system clock.
 */
module crt_twi_slave import crt_pkg::*; (
  // System
  input  wire logic clk,
  input  wire logic reset,
  // Link pins
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOe,
  // Core side
  crt_twi_if.slave  lnk
);
  logic [1:0] sclS_q, sdaS_q;
  logic sclP_q, sdaP_q, ackPh_q, rw_q, first_q;
  logic [3:0] bitCnt_q;
  logic [7:0] sh_q;
  crt_twi_st_t st_q;

  // Only the second stage feeds edge logic
  wire scl = sclS_q[1];
  wire sda = sdaS_q[1];
  wire sclRise = scl & ~sclP_q;
  wire sclFall = ~scl & sclP_q;
  wire startC  = scl & sclP_q & sdaP_q & ~sda;
  wire stopC   = scl & sclP_q & ~sdaP_q & sda;
  wire ownHit  = sh_q[7:1] == {ADDR_HIGH, lnk.devAddr, 1'b1};
  wire gcHit   = sh_q == GC_ADDR;
  wire rxPh    = (st_q == S_ADDR) | (st_q == S_WRITE);

  always_ff @(posedge clk) begin
    {sclS_q, sclP_q} <= {sclS_q[0], sclIn, sclS_q[1]};
    {sdaS_q, sdaP_q} <= {sdaS_q[0], sdaIn, sdaS_q[1]};
  end

  // Bit and byte sequencing; start and stop override everything except reset
  always_ff @(posedge clk) begin
    lnk.byteStb <= 1'b0;
    lnk.rdStart <= 1'b0;
    lnk.rdAck   <= 1'b0;
    if (reset) begin
      st_q <= S_IDLE;
      {sdaOe, ackPh_q, rw_q, first_q, lnk.genCall} <= '0;
      bitCnt_q     <= 4'h0;
      sh_q         <= 8'h00;
      lnk.byteData <= 8'h00;
      lnk.isCmd    <= 1'b0;
    end else if (startC | stopC) begin
      st_q     <= startC ? S_ADDR : S_IDLE;
      bitCnt_q <= 4'h0;
      {sdaOe, ackPh_q} <= 2'b00;
    end else if (rxPh & ~ackPh_q & sclRise) begin
      sh_q     <= {sh_q[6:0], sda};
      bitCnt_q <= bitCnt_q + 4'h1;
    end else if (rxPh & ~ackPh_q & sclFall & bitCnt_q == 4'h8) begin
      if (st_q == S_WRITE | ownHit | gcHit) begin
        {sdaOe, ackPh_q} <= 2'b11;
      end else begin
        st_q <= S_HOLD;
      end
      if (st_q == S_ADDR) begin
        rw_q        <= sh_q[0];
        lnk.genCall <= gcHit;
        lnk.rdStart <= sh_q[0] & ownHit;
      end
    end else if (rxPh & ackPh_q & sclFall) begin
      {ackPh_q, bitCnt_q} <= 5'h00;
      sdaOe <= 1'b0;
      if (st_q == S_WRITE) begin
        lnk.byteStb  <= 1'b1;
        lnk.byteData <= sh_q;
        lnk.isCmd    <= first_q;
        first_q      <= 1'b0;
      end else if (rw_q & ~lnk.genCall) begin
        st_q  <= S_READ;
        sh_q  <= lnk.rdData;
        sdaOe <= ~lnk.rdData[7];
      end else begin
        st_q    <= rw_q ? S_HOLD : S_WRITE;
        first_q <= 1'b1;
      end
    end else if (st_q == S_READ & ~ackPh_q & sclFall) begin
      if (bitCnt_q == 4'h7) begin
        {sdaOe, ackPh_q} <= 2'b01;
      end else begin
        sh_q     <= {sh_q[6:0], 1'b1};
        sdaOe    <= ~sh_q[6];
        bitCnt_q <= bitCnt_q + 4'h1;
      end
    end else if (st_q == S_READ & ackPh_q & sclRise) begin
      // Master acknowledge commits the byte; a not-ack ends the read
      lnk.rdAck <= ~sda;
      if (sda) begin
        st_q <= S_HOLD;
      end
    end else if (st_q == S_READ & ackPh_q & sclFall) begin
      {ackPh_q, bitCnt_q} <= 5'h00;
      sh_q  <= lnk.rdData;
      sdaOe <= ~lnk.rdData[7];
    end
  end
endmodule

// File: rtl/crt_top.sv
/*
 * Card reader command interpreter and interrupt collector. Decodes write
 * commands from the serial link into a byte register file, serves reads
 * from a read pointer, keeps sticky event flags, drives the shared
 * interrupt, power-down and edge-rate selections.
 * Assumes the activation sequencer shares clk and drives the answer
 * timeout strobes and capture value; analog status lines are asynchronous.
 */
module crt_top import crt_pkg::*; #(
  parameter int PORTS = 5
) (
  // System
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Serial link
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  output logic                          sdaOut,
  output logic                          sdaOe,
  input  wire logic [1:0]               addrPin,
  // Analog status, asynchronous
  input  wire logic [1:0]               cardPresentIn,
  input  wire logic [PORTS-1:0]         supplyGoodIn,
  input  wire logic                     auxGoodIn,
  input  wire logic                     overcurrentIn,
  input  wire logic [PORTS-1:0]         supplyRangeErrIn,
  // Activation sequencer, same clock
  input  wire logic [PORTS-1:0]         answerTimeoutStb,
  input  wire logic [15:0]              captureValue,
  // Interrupt
  output logic                          irqN,
  // Configuration
  output logic [REG_COUNT-1:0][7:0]     cfgRegs,
  output logic [PORTS-1:0][1:0]         clockRate,
  output logic [PORTS-1:0][1:0]         dataRiseRate,
  // Power and reset effects
  output logic                          primaryConverterOff,
  output logic                          secondaryConverterOff,
  output logic                          regulatorPowerDown,
  output logic                          emergencyDeact
);
  localparam int SW = 2 * PORTS + 6;

  crt_twi_if lnk ();

  logic          swRst_q;
  logic [SW-1:0] sync1_q, sync2_q, prev_q;
  logic [PORTS-1:0] settled_q, fault_q, tmo_q;
  logic [1:0]    chg_q;
  logic          oc_q, aux_q;
  logic [4:0]    wrIdx_q;
  logic [2:0]    wrLeft_q;
  crt_grp_t      rdGrp_q;
  logic [3:0]    rdIdx_q;
  logic [7:0]    rdByte;

  // Soft reset reinitializes registers and the serial slave
  wire rstAll = reset | swRst_q;

  crt_twi_slave u_slave (
    .clk   (clk),
    .reset (rstAll),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .sdaOe (sdaOe),
    .lnk   (lnk.slave)
  );

  // Two-stage synchronisers for pins; edges taken past the second stage
  always_ff @(posedge clk) begin
    sync1_q <= {addrPin, cardPresentIn, supplyGoodIn, auxGoodIn,
                overcurrentIn, supplyRangeErrIn};
    sync2_q <= sync1_q;
    prev_q  <= sync2_q;
  end

  wire [PORTS-1:0] rangeErr = sync2_q[PORTS-1:0];
  wire [PORTS-1:0] rangeErrP = prev_q[PORTS-1:0];
  wire             ocS   = sync2_q[PORTS];
  wire             ocP   = prev_q[PORTS];
  wire             auxGd = sync2_q[PORTS+1];
  wire             auxGdP = prev_q[PORTS+1];
  wire [PORTS-1:0] good  = sync2_q[2*PORTS+1:PORTS+2];
  wire [PORTS-1:0] goodP = prev_q[2*PORTS+1:PORTS+2];
  wire [1:0]       pres  = sync2_q[2*PORTS+3:2*PORTS+2];
  wire [1:0]       presP = prev_q[2*PORTS+3:2*PORTS+2];
  assign lnk.devAddr = sync2_q[SW-1:SW-2];
  assign lnk.rdData  = rdByte;

  // Command decode
  wire      cmdStb   = lnk.byteStb & lnk.isCmd;
  crt_cmd_t dec;
  assign dec = crt_decode(lnk.byteData);
  wire gcReset  = cmdStb & lnk.genCall & (lnk.byteData == GC_RESET);
  wire ownCmd   = cmdStb & ~lnk.genCall & dec.ok;
  wire resetHit = gcReset | (ownCmd & dec.rst);
  wire cfg0Hit  = ownCmd & (lnk.byteData[7:6] == 2'b10);
  wire pinHit   = ownCmd & ~lnk.byteData[7];
  wire dataHit  = lnk.byteStb & ~lnk.isCmd & ~lnk.genCall &
                  (wrLeft_q != 3'h0);

  // Register file write port selection
  wire       regWe    = cfg0Hit | pinHit | dataHit;
  wire [4:0] regWIdx  = cfg0Hit ? IDX_P1_CFG0 :
                        pinHit  ? IDX_P1_PIN  : wrIdx_q;
  wire [7:0] regWData = cfg0Hit ? {2'b10, lnk.byteData[5:0]} :
                        pinHit  ? {1'b0, lnk.byteData[6:0]} :
                        lnk.byteData;

  // Soft reset pulse and emergency deactivation if a port is powered
  wire anyActive;
  always_ff @(posedge clk) begin
    if (reset) begin
      swRst_q        <= 1'b0;
      emergencyDeact <= 1'b0;
    end else begin
      swRst_q        <= resetHit;
      emergencyDeact <= resetHit & anyActive;
    end
  end

  // Data byte sequencing inside a command
  always_ff @(posedge clk) begin
    if (rstAll) begin
      wrIdx_q  <= 5'h00;
      wrLeft_q <= 3'h0;
    end else if (cmdStb) begin
      // following bytes fill the group in order
      // Unknown commands zero the count so stale groups get no bytes
      wrIdx_q  <= dec.base;
      wrLeft_q <= ownCmd ? dec.len : 3'h0;
    end else if (dataHit) begin
      wrIdx_q  <= wrIdx_q + 5'h01;
      wrLeft_q <= wrLeft_q - 3'h1;
    end
  end

  // Register file storage
  always_ff @(posedge clk) begin
    if (rstAll) begin
      cfgRegs             <= '0;
      cfgRegs[IDX_P1_PIN] <= PIN_RESET;
      cfgRegs[IDX_TMR_HI] <= TMR_HI_RESET;
      cfgRegs[IDX_TMR_HI + 5'h01] <= TMR_LO_RESET;
    end else if (regWe) begin
      // grouped loads land at consecutive entries
      cfgRegs[regWIdx] <= regWData;
    end
  end

  // Read pointer: set by every known own write command, advanced on master ack
  always_ff @(posedge clk) begin
    if (rstAll) begin
      rdGrp_q <= G_SC1;
      rdIdx_q <= 4'h0;
    end else if (ownCmd) begin
      rdGrp_q <= dec.grp;
      rdIdx_q <= 4'h0;
    end else if (lnk.rdStart) begin
      rdIdx_q <= 4'h0;
    end else if (lnk.rdAck & (rdIdx_q != 4'hf)) begin
      rdIdx_q <= rdIdx_q + 4'h1;
    end
  end

  // Flag clear strobes, only after the master acked the carrying byte
  // clear waits for master ack
  wire ackFirst   = lnk.rdAck & (rdIdx_q == 4'h0);
  wire clrP1Stat  = ackFirst & (rdGrp_q == G_SC1);
  wire clrP1Cfg0  = lnk.rdAck & (rdGrp_q == G_SC1) &
                    (rdIdx_q == 4'h1);
  wire clrAux     = ackFirst & (rdGrp_q == G_AUX);
  wire [PORTS-1:0] clrSettled, clrErr, swTmo, swFlt, setTmo, setFlt;
  wire [PORTS-1:0] active, portPend;

  // Per-port flags, images and edge-rate choice
  genvar n;
  generate
    for (n = 0; n < PORTS; n++) begin : g_port
      wire [1:0] sel = cfgRegs[CFG0_IDX[n]][1:0];
      // Both slew bytes joined first; a concatenation cannot be sliced
      wire [15:0] slewAll = {cfgRegs[IDX_SLEW2], cfgRegs[IDX_SLEW1]};
      wire [1:0] mode = slewAll[2*n +: 2];
      wire       cfgWr = regWe & (regWIdx == CFG0_IDX[n]);
      if (n == 0) begin : g_p1
        // port one flags clear by their own byte
        assign clrSettled[n] = clrP1Stat;
        assign clrErr[n]     = clrP1Cfg0;
        // port one flags always reach the interrupt
        assign portPend[n]   = settled_q[n] | fault_q[n] | tmo_q[n];
      end else begin : g_pn
        assign clrSettled[n] = ackFirst & (rdGrp_q == crt_grp_t'(n + 1));
        assign clrErr[n]     = clrSettled[n];
        // masked port still flags but stays off the line
        assign portPend[n]   = (settled_q[n] | fault_q[n] | tmo_q[n] |
                                (n == 1 && chg_q[1])) &
                               ~cfgRegs[IDX_IRQ_MASK][n-1];
      end
      // software may set the timeout flag
      assign swTmo[n]  = cfgWr & regWData[B_TMO];
      // software may set the fault flag
      assign swFlt[n]  = cfgWr & regWData[B_FLT];
      assign setTmo[n] = answerTimeoutStb[n] | swTmo[n];
      assign setFlt[n] = (rangeErr[n] & ~rangeErrP[n]) | swFlt[n];
      assign active[n] = sel != 2'b00;

      always_ff @(posedge clk) begin
        if (rstAll) begin
          {settled_q[n], fault_q[n], tmo_q[n]} <= 3'b000;
          clockRate[n]    <= 2'b00;
          dataRiseRate[n] <= 2'b00;
        end else begin
          settled_q[n] <= (good[n] & ~goodP[n]) |
                          (settled_q[n] & ~clrSettled[n]);
          fault_q[n]   <= setFlt[n] | (fault_q[n] & ~clrErr[n]);
          tmo_q[n]     <= setTmo[n] | (tmo_q[n] & ~clrErr[n]);
          // automatic follows supply field, else forced
          clockRate[n]    <= (mode == SLEW_AUTO) ? sel : mode;
          // data pin rate governs rising edge only
          dataRiseRate[n] <= (mode == SLEW_AUTO) ? sel : mode;
        end
      end
    end
  endgenerate

  assign anyActive = |active;

  // Card change, overcurrent and aux flags; a set beats a clear
  wire swChg1 = cfg0Hit & regWData[B_CHG];
  wire swOc   = cfg0Hit & regWData[B_OC];
  wire swChg2 = regWe & (regWIdx == IDX_P2_CFG0) & regWData[B_CHG];
  always_ff @(posedge clk) begin
    if (rstAll) begin
      chg_q <= 2'b00;
      oc_q  <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      chg_q[0] <= (pres[0] ^ presP[0]) | swChg1 | (chg_q[0] & ~clrP1Cfg0);
      chg_q[1] <= (pres[1] ^ presP[1]) | swChg2 |
                  (chg_q[1] & ~clrSettled[1]);
      oc_q     <= (ocS & ~ocP) | swOc | (oc_q & ~clrP1Cfg0);
      aux_q    <= (auxGd & ~auxGdP) | (aux_q & ~clrAux);
    end
  end

  // any unmasked flag pulls the line low
  wire pending = (|portPend) | chg_q[0] | oc_q | aux_q;

  // Interrupt, link data and power-down outputs
  always_ff @(posedge clk) begin
    if (rstAll) begin
      irqN   <= 1'b1;
      sdaOut <= 1'b0;
      {primaryConverterOff, secondaryConverterOff} <= 2'b00;
      regulatorPowerDown <= 1'b0;
    end else begin
      // active low only, driven high while no flag is pending
      irqN   <= ~pending;
      sdaOut <= 1'b0;
      primaryConverterOff   <= cfgRegs[IDX_P1_CFG1][B_PRIM_OFF];
      secondaryConverterOff <= cfgRegs[IDX_AUX][B_SEC_OFF];
      // both off bits power down the regulator
      regulatorPowerDown    <= cfgRegs[IDX_P1_CFG1][B_PRIM_OFF] &
                               cfgRegs[IDX_AUX][B_SEC_OFF];
    end
  end

  // Status images, non-clearing status merged with sticky flags
  // presence and supply-good shown live
  wire [7:0] p1Status = {2'b00, pres[0], good[0], 1'b0,
                         settled_q[0], 2'b00};
  wire [7:0] p1Cfg0   = {2'b10, tmo_q[0], chg_q[0], oc_q, fault_q[0],
                         cfgRegs[IDX_P1_CFG0][1:0]};
  wire [7:0] commonSt = {1'b0, pres[1], auxGd, good};
  wire [7:0] auxImg   = {aux_q, auxGd, cfgRegs[IDX_AUX][5:0]};
  wire [3:0] rdM1     = rdIdx_q - 4'h1;

  function automatic logic [7:0] portImg(input int p);
    portImg = {settled_q[p], good[p], tmo_q[p], p == 1 && chg_q[1],
               1'b0, fault_q[p], cfgRegs[CFG0_IDX[p]][1:0]};
  endfunction

  // Read byte selection; anything past a group end reads FFh
  // capture bytes let the host judge timeouts
  always_comb begin
    rdByte = 8'hff;
    unique case (rdGrp_q)
      G_SC1: begin
        if (rdIdx_q == 4'h0) begin
          rdByte = p1Status;
        end else if (rdIdx_q == 4'h1) begin
          rdByte = p1Cfg0;
        end else if (rdIdx_q <= 4'h8) begin
          rdByte = cfgRegs[{1'b0, rdM1}];
        end else if (rdIdx_q == 4'h9) begin
          rdByte = captureValue[15:8];
        end else if (rdIdx_q == 4'ha) begin
          rdByte = captureValue[7:0];
        end
      end
      G_COM: begin
        if (rdIdx_q == 4'h0) begin
          rdByte = commonSt;
        end else if (rdIdx_q <= 4'h3) begin
          rdByte = cfgRegs[IDX_COMMON + {1'b0, rdM1}];
        end
      end
      G_P2, G_P3, G_P4, G_P5: begin
        // port two has three bytes, others two
        if (rdIdx_q == 4'h0) begin
          rdByte = portImg(int'(rdGrp_q) - 1);
        end else if (rdIdx_q == 4'h1 ||
                     (rdIdx_q == 4'h2 && rdGrp_q == G_P2)) begin
          rdByte = cfgRegs[CFG0_IDX[int'(rdGrp_q) - 1] + {1'b0, rdIdx_q}];
        end
      end
      G_AUX: begin
        if (rdIdx_q == 4'h0) begin
          rdByte = auxImg;
        end else if (rdIdx_q == 4'h1) begin
          rdByte = cfgRegs[IDX_REGUL];
        end
      end
      G_SLEW: begin
        if (rdIdx_q <= 4'h2) begin
          rdByte = cfgRegs[IDX_SLEW1 + {1'b0, rdIdx_q}];
        end
      end
    endcase
  end
endmodule

// File: test/crt_top_props.sv
/* Port checks for the command and interrupt block.
   Assumes one clock domain with a synchronous active-high reset. */
module crt_top_props import crt_pkg::*; #(
  parameter int PORTS = 5
) (
  // System
  input wire logic                      clk,
  input wire logic                      reset,
  // Link and interrupt
  input wire logic                      sdaOut,
  input wire logic                      irqN,
  // Configuration and power
  input wire logic [REG_COUNT-1:0][7:0] cfgRegs,
  input wire logic [PORTS-1:0][1:0]     clockRate,
  input wire logic                      primaryConverterOff,
  input wire logic                      secondaryConverterOff,
  input wire logic                      regulatorPowerDown,
  input wire logic                      emergencyDeact
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Interrupt and link pin levels
  property p_idle; disable iff (1'b0) reset |=> irqN; endproperty
  a_idle: assert property (p_idle) else $error("irq not idle");
  property p_od; sdaOut == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_p1;
    $changed(cfgRegs[0]) && (|cfgRegs[0][5:2]) |=> !irqN;
  endproperty
  a_p1: assert property (p_p1) else $error("port1 flag no irq");
  property p_clr;
    $changed(cfgRegs[0]) && (|cfgRegs[0][5:2]) |=> ##1 !irqN;
  endproperty
  a_clr: assert property (p_clr) else $error("irq freed early");
  // Power-down follows both converter bits, left only by writes
  property p_pd;
    (primaryConverterOff && secondaryConverterOff) [*2] |-> regulatorPowerDown;
  endproperty
  a_pd: assert property (p_pd) else $error("no power-down");
  property p_stay; $fell(primaryConverterOff) |-> !cfgRegs[1][5]; endproperty
  a_stay: assert property (p_stay) else $error("left power-down");
  // Automatic rate follows select field once settings rest
  property p_auto;
    $stable(cfgRegs[0]) && $stable(cfgRegs[IDX_SLEW1]) &&
    cfgRegs[IDX_SLEW1][1:0] == SLEW_AUTO |-> clockRate[0] == cfgRegs[0][1:0];
  endproperty
  a_auto: assert property (p_auto) else $error("auto rate wrong");
  property p_em; emergencyDeact |-> ##[0:1] cfgRegs[6] == TMR_HI_RESET;
  endproperty
  a_em: assert property (p_em) else $error("no reinit");
endmodule

bind crt_top crt_top_props #(.PORTS(PORTS)) crt_top_props_inst (.clk,
  .reset, .sdaOut, .irqN, .cfgRegs, .clockRate, .primaryConverterOff,
  .secondaryConverterOff, .regulatorPowerDown, .emergencyDeact);

// File: test/crt_host_model.sv
/* Two-wire master standing in for the host controller.
   Assumes a pull-up: the line is low while any side pulls it. */
module crt_host_model (
  // Link
  output logic      sclOut,
  output logic      sdaPull,
  input  wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25; // Quarter of the 125 ns bit
  // Clock stands high, data released, between frames
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic start;
    sdaPull = 1'b1;
    #Q sclOut = 1'b0;
    #Q;
  endtask
  task automatic stop;
    sdaPull = 1'b1;
    #Q sclOut = 1'b1;
    #Q sdaPull = 1'b0;
    #Q;
  endtask
  task automatic xfer(input logic [7:0] w, input logic m,
                      output logic [7:0] r, output logic a);
    for (int i = 8; i >= 0; i--) begin
      sdaPull = (i > 0) ? !w[i-1] : !m;
      #Q sclOut = 1'b1;
      #Q if (i > 0) r[i-1] = sdaLine; else a = sdaLine;
      #Q sclOut = 1'b0;
      #Q;
    end
  endtask
endmodule

// File: test/crt_top_test.sv
/* Self-checking bench for the command and interrupt block.
   Assumes the host model masters the link; supply-good rises and range error and timeout pulse once, other status inputs rest. */
module crt_top_test import crt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic [4:0]       ev = 5'h00;
  logic [4:0]       good = 5'h00;
  logic             scl, pull, sdaOe, irqN, pOff, sOff, rOff;
  logic [24:0][7:0] regs;
  logic [7:0]       rb [7];
  int               failures = 0;
  int               n_compared = 0;
  wire              sda = !(pull || sdaOe);
  always #2 clk = !clk;
  crt_host_model crt_host_model_inst (.sclOut(scl), .sdaPull(pull),
    .sdaLine(sda));
  crt_top crt_top_inst (.clk, .reset, .sclIn(scl), .sdaIn(sda),
    .sdaOut(), .sdaOe, .addrPin(2'h1), .cardPresentIn(2'h0),
    .supplyGoodIn(good), .auxGoodIn(1'b0), .overcurrentIn(1'b0),
    .supplyRangeErrIn(ev), .answerTimeoutStb(ev), .captureValue(16'h0),
    .irqN, .cfgRegs(regs), .clockRate(), .dataRiseRate(),
    .primaryConverterOff(pOff), .secondaryConverterOff(sOff),
    .regulatorPowerDown(rOff), .emergencyDeact());
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Write frame; every byte must be acked, unknown ones too
  task automatic wr(input logic [7:0] q [$]);
    logic [7:0] r;
    logic       a;
    crt_host_model_inst.start();
    foreach (q[i]) begin
      crt_host_model_inst.xfer(q[i], 1'b1, r, a);
      chk("ack", {7'h0, a}, 8'h00);
    end
    crt_host_model_inst.stop();
  endtask
  // Read frame; the last byte is not acked so it is not consumed
  task automatic rd(input int n);
    logic a;
    crt_host_model_inst.start();
    crt_host_model_inst.xfer(8'h47, 1'b1, rb[0], a);
    for (int i = 0; i < n; i++)
      crt_host_model_inst.xfer(8'hff, i == n - 1, rb[i], a);
    crt_host_model_inst.stop();
  endtask
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected 70 us of traffic
  initial begin
    #200us;
    failures++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    chk("pin", regs[IDX_P1_PIN], PIN_RESET);
    chk("irqN", {7'h0, irqN}, 8'h01);
    wr('{8'h46, CMD_TIMER, 8'h12, 8'h34});
    chk("tmr", regs[IDX_TMR_HI+1], 8'h34);
    wr('{8'h46, CMD_RESET});
    chk("soft", regs[IDX_TMR_HI], TMR_HI_RESET);
    wr('{8'h46, CMD_P4, 8'h02, 8'h5a, 8'h77});
    chk("p4", regs[IDX_P4_CFG0+1], 8'h5a);
    chk("extra", regs[IDX_P5_CFG0], 8'h00);
    wr('{GC_ADDR, GC_RESET});
    chk("gcall", regs[IDX_P4_CFG0+1], 8'h00);
    wr('{8'h46, CMD_COMMON, 8'h00, 8'h00, 8'h0f});
    rd(5);
    chk("mask", rb[3], 8'h0f);
    chk("end", rb[4], 8'hff);
    wr('{8'h46, 8'h35});
    wr('{8'h46, 8'hf0});
    chk("pinw", regs[IDX_P1_PIN], 8'h35);
    @(posedge clk) #1 ev = 5'h1f;
    good = 5'h1f;
    @(posedge clk) #1 ev = 5'h00;
    repeat (8) @(posedge clk);
    chk("irqN", {7'h0, irqN}, 8'h00);
    rd(7);
    chk("ptr", rb[6], 8'h35);
    chk("settled", rb[0] & 8'h04, 8'h04);
    chk("flags", rb[1] & 8'h24, 8'h24);
    repeat (8) @(posedge clk);
    chk("irqN", {7'h0, irqN}, 8'h01);
    wr('{8'h46, 8'h80, 8'h20, 8'h00, 8'h00, 8'h00});
    chk("pd1", {6'h0, pOff, rOff}, 8'h02);
    wr('{8'h46, CMD_AUX, 8'h20, 8'h00});
    chk("pd2", {6'h0, sOff, rOff}, 8'h03);
    wr('{8'h46, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("pd3", {7'h0, rOff}, 8'h00);
    wr('{8'h46, 8'ha4});
    chk("swset", {7'h0, irqN}, 8'h00);
    rd(3);
    chk("swflags", rb[1] & 8'h24, 8'h24);
    chk("irqN", {7'h0, irqN}, 8'h01);
    complete_run();
  end
endmodule
